// [shared/ccb_pkg.sv]
// Package with register map, field layouts, codes and reset values of the capture/compare buffer block.
package ccb_pkg;

  // Register port widths.
  localparam int unsigned CCB_ADDR_W = 4;
  localparam int unsigned CCB_DATA_W = 16;

  // Register word indices on the register port.
  localparam logic [3:0] CCB_ADDR_MODE = 4'h0;    // timer_mode_reg.
  localparam logic [3:0] CCB_ADDR_CTRL1 = 4'h1;   // timer_control_reg1.
  localparam logic [3:0] CCB_ADDR_STATUS = 4'h2;  // timer_status_reg.
  localparam logic [3:0] CCB_ADDR_IO_AB = 4'h3;   // io_select_reg_ab.
  localparam logic [3:0] CCB_ADDR_IO_CD = 4'h4;   // io_select_reg_cd.
  localparam logic [3:0] CCB_ADDR_COUNT = 4'h5;   // timer_counter.
  localparam logic [3:0] CCB_ADDR_GRA = 4'h6;     // general_reg_a.
  localparam logic [3:0] CCB_ADDR_GRB = 4'h7;     // general_reg_b.
  localparam logic [3:0] CCB_ADDR_GRC = 4'h8;     // general_reg_c.
  localparam logic [3:0] CCB_ADDR_GRD = 4'h9;     // general_reg_d.
  localparam logic [3:0] CCB_ADDR_MASK = 4'ha;    // Interrupt mask, same layout as the status register.

  // Operating modes held in the mode field of timer_mode_reg.
  localparam logic [1:0] CCB_MODE_TIMER = 2'h0;
  localparam logic [1:0] CCB_MODE_PWM = 2'h1;
  localparam logic [1:0] CCB_MODE_PWM2 = 2'h2;

  // Layout of timer_mode_reg.
  typedef struct packed {
    logic count_start_bit;   // Bit 7: counter runs while set.
    logic [2:0] rsvd;        // Bits 6..4: read as zero.
    logic buffer_b_select;   // Bit 3: general_reg_d buffers general_reg_b.
    logic buffer_a_select;   // Bit 2: general_reg_c buffers general_reg_a.
    logic [1:0] mode;        // Bits 1..0: operating mode.
  } ccb_mode_t;
  localparam logic [7:0] CCB_MODE_WMASK = 8'h8f;
  localparam logic [7:0] CCB_MODE_RESET = 8'h00;

  // Layout of timer_control_reg1.
  typedef struct packed {
    logic [3:0] rsvd;                // Bits 7..4: read as zero.
    logic clear_on_match_a;          // Bit 3: counter clears on a match with general_reg_a.
    logic [2:0] clock_select_field;  // Bits 2..0: count source.
  } ccb_ctrl_t;
  localparam logic [7:0] CCB_CTRL_WMASK = 8'h0f;
  localparam logic [7:0] CCB_CTRL_RESET = 8'h00;

  // Count source codes of clock_select_field.
  localparam logic [2:0] CCB_CKS_F1 = 3'h0;
  localparam logic [2:0] CCB_CKS_F2 = 3'h1;
  localparam logic [2:0] CCB_CKS_F4 = 3'h2;
  localparam logic [2:0] CCB_CKS_F8 = 3'h3;
  localparam logic [2:0] CCB_CKS_F32 = 3'h4;
  localparam logic [2:0] CCB_CKS_EXT = 3'h5;
  localparam logic [2:0] CCB_CKS_OSC = 3'h6;

  // Prescaler width and the tick patterns of the divided clocks.
  localparam int unsigned CCB_DIV_W = 5;
  localparam logic [4:0] CCB_DIV_F2_MASK = 5'h01;
  localparam logic [4:0] CCB_DIV_F4_MASK = 5'h03;
  localparam logic [4:0] CCB_DIV_F8_MASK = 5'h07;
  localparam logic [4:0] CCB_DIV_F32_MASK = 5'h1f;

  // Layout of io_select_reg_ab.
  typedef struct packed {
    logic rsvd;                    // Bit 7: read as zero.
    logic chan_b_capture_select;   // Bit 6: channel B is input capture.
    logic [1:0] edge_b;            // Bits 5..4: edge_select_field of channel B.
    logic chan_a_capture_source;   // Bit 3: channel A captures on the alternate source.
    logic chan_a_capture_select;   // Bit 2: channel A is input capture.
    logic [1:0] edge_a;            // Bits 1..0: edge_select_field of channel A.
  } ccb_io_ab_t;
  localparam logic [7:0] CCB_IO_AB_WMASK = 8'h7f;
  localparam logic [7:0] CCB_IO_AB_RESET = 8'h00;

  // Layout of io_select_reg_cd.
  typedef struct packed {
    logic rsvd_hi;                 // Bit 7: read as zero.
    logic chan_d_capture_select;   // Bit 6: channel D is input capture.
    logic [1:0] edge_d;            // Bits 5..4: edge_select_field of channel D.
    logic rsvd_lo;                 // Bit 3: read as zero.
    logic chan_c_capture_select;   // Bit 2: channel C is input capture.
    logic [1:0] edge_c;            // Bits 1..0: edge_select_field of channel C.
  } ccb_io_cd_t;
  localparam logic [7:0] CCB_IO_CD_WMASK = 8'h77;
  localparam logic [7:0] CCB_IO_CD_RESET = 8'h00;

  // Edge select codes; code 11 also means both edges.
  localparam logic [1:0] CCB_EDGE_RISE = 2'h0;
  localparam logic [1:0] CCB_EDGE_FALL = 2'h1;
  localparam logic [1:0] CCB_EDGE_BOTH = 2'h2;

  // Status and mask bit positions.
  localparam int unsigned CCB_ST_W = 5;
  localparam int unsigned CCB_ST_A = 0;
  localparam int unsigned CCB_ST_B = 1;
  localparam int unsigned CCB_ST_C = 2;
  localparam int unsigned CCB_ST_D = 3;
  localparam int unsigned CCB_ST_OVF = 4;
  localparam logic [4:0] CCB_ST_RESET = 5'h00;
  localparam logic [4:0] CCB_MASK_RESET = 5'h00;

  // Index of each sampled input in the edge detector bank.
  localparam int unsigned CCB_NPIN = 8;
  localparam int unsigned CCB_PIN_A = 0;
  localparam int unsigned CCB_PIN_B = 1;
  localparam int unsigned CCB_PIN_C = 2;
  localparam int unsigned CCB_PIN_D = 3;
  localparam int unsigned CCB_PIN_TRIG = 4;
  localparam int unsigned CCB_PIN_EXT = 5;
  localparam int unsigned CCB_PIN_OSC = 6;
  localparam int unsigned CCB_PIN_ALT = 7;

  // Reset value of counter and general registers.
  localparam logic [15:0] CCB_WORD_RESET = 16'h0000;
  localparam logic [15:0] CCB_COUNT_MAX = 16'hffff;

endpackage : ccb_pkg

// [verilog/ccb_edge_sel.sv]
// Edge detector with a selectable edge for one synchronous input.
`timescale 1ns/1ps
module ccb_edge_sel (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic [1:0] i_edge_sel,
  output logic o_edge
);

  // Level of the input at the previous edge.
  logic prev;

  // Remember the last level so a change can be seen in the current cycle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= i_pin;
    end
  end

  // Pick the requested edge; both codes above falling mean any change.
  always_comb begin
    case (i_edge_sel)
      ccb_pkg::CCB_EDGE_RISE: begin
        o_edge = i_pin & ~prev;
      end
      ccb_pkg::CCB_EDGE_FALL: begin
        o_edge = ~i_pin & prev;
      end
      default: begin
        o_edge = i_pin ^ prev;
      end
    endcase
  end

endmodule : ccb_edge_sel

// [verilog/ccb_timer.sv]
// Capture/compare timer core with count source selection and general register buffering.
//
// Summary of operation
// - I/O select registers act only in timer mode.
// - Channel A source option needs channel A capture.
// - Capture edge follows each channel's edge field.
// - Clock field selects f1, f2, f4, f8, f32.
// - Code 110b counts the fast oscillator clock.
// - Code 101b counts external pin rising edges.
// - Buffer selects make C buffer A, D buffer B.
// - Capture copies old A/B to buffer first.
// - Own compare match loads A/B from their buffer, except in PWM2.
// - PWM2 loads B from D on A match or trigger.
// - C/D flags still set on their compare match.
// - C/D flags set on their capture pin edge.
// - Flags clear by writing 0 after reading 1.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module ccb_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ccb_pkg::CCB_ADDR_W-1:0] i_addr,
  input wire logic [ccb_pkg::CCB_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ccb_pkg::CCB_DATA_W-1:0] o_rdata,
  input wire logic i_chan_a_pin,
  input wire logic i_chan_b_pin,
  input wire logic i_chan_c_pin,
  input wire logic i_chan_d_pin,
  input wire logic i_trigger_pin,
  input wire logic i_external_clock_pin,
  input wire logic i_fast_onchip_osc_clock,
  input wire logic i_fast_osc_on,
  input wire logic i_capture_alt_source,
  output logic o_irq,
  output logic [ccb_pkg::CCB_DATA_W-1:0] o_count_value,
  output logic [3:0] o_match
);

  // Software visible control registers.
  ccb_pkg::ccb_mode_t mode_reg;      // timer_mode_reg.
  ccb_pkg::ccb_ctrl_t ctrl_reg;      // timer_control_reg1.
  ccb_pkg::ccb_io_ab_t io_ab_reg;    // io_select_reg_ab.
  ccb_pkg::ccb_io_cd_t io_cd_reg;    // io_select_reg_cd.
  logic [ccb_pkg::CCB_ST_W-1:0] status;     // timer_status_reg flags.
  logic [ccb_pkg::CCB_ST_W-1:0] irq_mask;   // Interrupt mask.
  logic [ccb_pkg::CCB_ST_W-1:0] armed;      // Flags seen as one by the last status read.

  // Counter and general registers.
  logic [15:0] counter;
  logic [15:0] gra;
  logic [15:0] grb;
  logic [15:0] grc;
  logic [15:0] grd;

  // Prescaler for the divided system clocks.
  logic [ccb_pkg::CCB_DIV_W-1:0] div;

  // Sampled inputs, their edge selects and detected edges.
  logic [ccb_pkg::CCB_NPIN-1:0] pins;
  logic [1:0] edge_sel [ccb_pkg::CCB_NPIN];
  logic [ccb_pkg::CCB_NPIN-1:0] edges;

  // Decoded register strobes.
  logic wr_mode, wr_ctrl, wr_status, wr_io_ab, wr_io_cd, wr_count;
  logic wr_gra, wr_grb, wr_grc, wr_grd, wr_mask, rd_status;

  // Mode and channel decode.
  logic is_timer, is_pwm2;
  logic cap_a, cap_b, cap_c, cap_d;
  logic cap_ev_a, cap_ev_b, cap_ev_c, cap_ev_d;
  logic match_a, match_b, match_c, match_d;
  logic buf_a, buf_b, trig_ev;
  logic raw_tick, tick, clear_cnt, ovf_ev;
  logic [ccb_pkg::CCB_ST_W-1:0] flag_set;
  logic [ccb_pkg::CCB_ST_W-1:0] flag_clr;
  logic [ccb_pkg::CCB_ST_W-1:0] next_status;

  // Register strobes; each write or read touches at most one word.
  assign wr_mode = i_wr && (i_addr == ccb_pkg::CCB_ADDR_MODE);
  assign wr_ctrl = i_wr && (i_addr == ccb_pkg::CCB_ADDR_CTRL1);
  assign wr_status = i_wr && (i_addr == ccb_pkg::CCB_ADDR_STATUS);
  assign wr_io_ab = i_wr && (i_addr == ccb_pkg::CCB_ADDR_IO_AB);
  assign wr_io_cd = i_wr && (i_addr == ccb_pkg::CCB_ADDR_IO_CD);
  assign wr_count = i_wr && (i_addr == ccb_pkg::CCB_ADDR_COUNT);
  assign wr_gra = i_wr && (i_addr == ccb_pkg::CCB_ADDR_GRA);
  assign wr_grb = i_wr && (i_addr == ccb_pkg::CCB_ADDR_GRB);
  assign wr_grc = i_wr && (i_addr == ccb_pkg::CCB_ADDR_GRC);
  assign wr_grd = i_wr && (i_addr == ccb_pkg::CCB_ADDR_GRD);
  assign wr_mask = i_wr && (i_addr == ccb_pkg::CCB_ADDR_MASK);
  assign rd_status = i_rd && (i_addr == ccb_pkg::CCB_ADDR_STATUS);

  // Input bank: channel pins, trigger, clock pins and alternate capture source.
  assign pins = {i_capture_alt_source, i_fast_onchip_osc_clock, i_external_clock_pin, i_trigger_pin,
                 i_chan_d_pin, i_chan_c_pin, i_chan_b_pin, i_chan_a_pin};

  // Edge choice per input; the clock and trigger inputs count rising edges only.
  assign edge_sel[ccb_pkg::CCB_PIN_A] = io_ab_reg.edge_a;
  assign edge_sel[ccb_pkg::CCB_PIN_B] = io_ab_reg.edge_b;
  assign edge_sel[ccb_pkg::CCB_PIN_C] = io_cd_reg.edge_c;
  assign edge_sel[ccb_pkg::CCB_PIN_D] = io_cd_reg.edge_d;
  assign edge_sel[ccb_pkg::CCB_PIN_TRIG] = ccb_pkg::CCB_EDGE_RISE;
  assign edge_sel[ccb_pkg::CCB_PIN_EXT] = ccb_pkg::CCB_EDGE_RISE;
  assign edge_sel[ccb_pkg::CCB_PIN_OSC] = ccb_pkg::CCB_EDGE_RISE;
  assign edge_sel[ccb_pkg::CCB_PIN_ALT] = io_ab_reg.edge_a;

  // One detector per input; a pin narrower than a cycle can be missed, so
  // the external clock needs wide pulses from the outside.
  genvar gi;
  generate
    for (gi = 0; gi < ccb_pkg::CCB_NPIN; gi++) begin : g_edge
      ccb_edge_sel u_edge (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pin(pins[gi]),
        .i_edge_sel(edge_sel[gi]),
        .o_edge(edges[gi])
      );
    end
  endgenerate

  // Mode decode; code 11 behaves as plain PWM.
  assign is_timer = (mode_reg.mode == ccb_pkg::CCB_MODE_TIMER);
  assign is_pwm2 = (mode_reg.mode == ccb_pkg::CCB_MODE_PWM2);
  assign buf_a = mode_reg.buffer_a_select;
  assign buf_b = mode_reg.buffer_b_select;

  // Capture selects count only in timer mode; PWM modes are always compare.
  assign cap_a = is_timer && io_ab_reg.chan_a_capture_select;
  assign cap_b = is_timer && io_ab_reg.chan_b_capture_select;
  assign cap_c = is_timer && io_cd_reg.chan_c_capture_select;
  assign cap_d = is_timer && io_cd_reg.chan_d_capture_select;

  // Capture events; the alternate source replaces pin A only for a capturing channel A.
  assign cap_ev_a = cap_a && (io_ab_reg.chan_a_capture_source ? edges[ccb_pkg::CCB_PIN_ALT]
                                                              : edges[ccb_pkg::CCB_PIN_A]);
  assign cap_ev_b = cap_b && edges[ccb_pkg::CCB_PIN_B];
  assign cap_ev_c = cap_c && edges[ccb_pkg::CCB_PIN_C];
  assign cap_ev_d = cap_d && edges[ccb_pkg::CCB_PIN_D];
  assign trig_ev = is_pwm2 && edges[ccb_pkg::CCB_PIN_TRIG];

  // Count source selection, the same in every mode.
  always_comb begin
    case (ctrl_reg.clock_select_field)
      ccb_pkg::CCB_CKS_F1: begin
        raw_tick = 1'b1;
      end
      ccb_pkg::CCB_CKS_F2: begin
        raw_tick = ((div & ccb_pkg::CCB_DIV_F2_MASK) == ccb_pkg::CCB_DIV_F2_MASK);
      end
      ccb_pkg::CCB_CKS_F4: begin
        raw_tick = ((div & ccb_pkg::CCB_DIV_F4_MASK) == ccb_pkg::CCB_DIV_F4_MASK);
      end
      ccb_pkg::CCB_CKS_F8: begin
        raw_tick = ((div & ccb_pkg::CCB_DIV_F8_MASK) == ccb_pkg::CCB_DIV_F8_MASK);
      end
      ccb_pkg::CCB_CKS_F32: begin
        raw_tick = ((div & ccb_pkg::CCB_DIV_F32_MASK) == ccb_pkg::CCB_DIV_F32_MASK);
      end
      ccb_pkg::CCB_CKS_EXT: begin
        raw_tick = edges[ccb_pkg::CCB_PIN_EXT];
      end
      ccb_pkg::CCB_CKS_OSC: begin
        // An oscillator that is still off yields no ticks at all.
        raw_tick = i_fast_osc_on && edges[ccb_pkg::CCB_PIN_OSC];
      end
      default: begin
        raw_tick = 1'b0;
      end
    endcase
  end
  assign tick = raw_tick && mode_reg.count_start_bit;

  // Compare matches are taken on a count tick so each value matches once.
  assign match_a = tick && !cap_a && (counter == gra);
  assign match_b = tick && !cap_b && (counter == grb);
  assign match_c = tick && !cap_c && (counter == grc);
  assign match_d = tick && !cap_d && (counter == grd);

  // Capture use keeps the counter free running whatever the clear bit says.
  assign clear_cnt = ctrl_reg.clear_on_match_a && match_a;
  assign ovf_ev = tick && !clear_cnt && (counter == ccb_pkg::CCB_COUNT_MAX);

  // Flag sources, all in the cycle of the event.
  assign flag_set[ccb_pkg::CCB_ST_A] = cap_ev_a || match_a;
  assign flag_set[ccb_pkg::CCB_ST_B] = cap_ev_b || match_b;
  assign flag_set[ccb_pkg::CCB_ST_C] = cap_ev_c || match_c;
  assign flag_set[ccb_pkg::CCB_ST_D] = cap_ev_d || match_d;
  assign flag_set[ccb_pkg::CCB_ST_OVF] = ovf_ev;

  // A write of zero clears only a flag that the last read saw as one.
  assign flag_clr = wr_status ? (armed & ~i_wdata[ccb_pkg::CCB_ST_W-1:0]) : '0;
  // A new event beats a clear in the same cycle.
  assign next_status = (status & ~flag_clr) | flag_set;

  // Free running prescaler for f2 to f32.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // Control registers; reserved bits are masked so they read as zero.
  // Clock settings are assumed to change only while stopped.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= ccb_pkg::ccb_mode_t'(ccb_pkg::CCB_MODE_RESET);
      ctrl_reg <= ccb_pkg::ccb_ctrl_t'(ccb_pkg::CCB_CTRL_RESET);
      io_ab_reg <= ccb_pkg::ccb_io_ab_t'(ccb_pkg::CCB_IO_AB_RESET);
      io_cd_reg <= ccb_pkg::ccb_io_cd_t'(ccb_pkg::CCB_IO_CD_RESET);
      irq_mask <= ccb_pkg::CCB_MASK_RESET;
    end else begin
      if (wr_mode) begin
        mode_reg <= ccb_pkg::ccb_mode_t'(i_wdata[7:0] & ccb_pkg::CCB_MODE_WMASK);
      end
      if (wr_ctrl) begin
        ctrl_reg <= ccb_pkg::ccb_ctrl_t'(i_wdata[7:0] & ccb_pkg::CCB_CTRL_WMASK);
      end
      if (wr_io_ab) begin
        io_ab_reg <= ccb_pkg::ccb_io_ab_t'(i_wdata[7:0] & ccb_pkg::CCB_IO_AB_WMASK);
      end
      if (wr_io_cd) begin
        io_cd_reg <= ccb_pkg::ccb_io_cd_t'(i_wdata[7:0] & ccb_pkg::CCB_IO_CD_WMASK);
      end
      if (wr_mask) begin
        irq_mask <= i_wdata[ccb_pkg::CCB_ST_W-1:0];
      end
    end
  end

  // Status flags and the read-arming that their clear depends on.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= ccb_pkg::CCB_ST_RESET;
      armed <= '0;
    end else begin
      status <= next_status;
      if (rd_status) begin
        armed <= status;
      end else if (wr_status) begin
        armed <= '0;
      end
    end
  end

  // Counter; a software write loses to nothing but is only sensible while stopped.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      counter <= ccb_pkg::CCB_WORD_RESET;
    end else if (wr_count) begin
      counter <= i_wdata;
    end else if (tick) begin
      if (clear_cnt) begin
        counter <= ccb_pkg::CCB_WORD_RESET;
      end else begin
        counter <= counter + 16'h0001;
      end
    end
  end

  // General register A: capture value, or reload from C on a match while buffered outside PWM2.
  // Hardware transfers win over a software write in the same cycle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gra <= ccb_pkg::CCB_WORD_RESET;
    end else if (cap_ev_a) begin
      gra <= counter;
    end else if (buf_a && !is_pwm2 && match_a) begin
      gra <= grc;
    end else if (wr_gra) begin
      gra <= i_wdata;
    end
  end

  // General register C: buffer of A when selected, else its own capture register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grc <= ccb_pkg::CCB_WORD_RESET;
    end else if (buf_a && cap_ev_a) begin
      grc <= gra;
    end else if (!buf_a && cap_ev_c) begin
      grc <= counter;
    end else if (wr_grc) begin
      grc <= i_wdata;
    end
  end

  // General register B: capture value, or reload from D on a match or PWM2 trigger.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grb <= ccb_pkg::CCB_WORD_RESET;
    end else if (cap_ev_b) begin
      grb <= counter;
    end else if (buf_b && is_pwm2 && (match_a || trig_ev)) begin
      grb <= grd;
    end else if (buf_b && !is_pwm2 && match_b) begin
      grb <= grd;
    end else if (wr_grb) begin
      grb <= i_wdata;
    end
  end

  // General register D: buffer of B when selected, else its own capture register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grd <= ccb_pkg::CCB_WORD_RESET;
    end else if (buf_b && cap_ev_b) begin
      grd <= grb;
    end else if (!buf_b && cap_ev_d) begin
      grd <= counter;
    end else if (wr_grd) begin
      grd <= i_wdata;
    end
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        ccb_pkg::CCB_ADDR_MODE: begin
          o_rdata <= {8'h00, mode_reg};
        end
        ccb_pkg::CCB_ADDR_CTRL1: begin
          o_rdata <= {8'h00, ctrl_reg};
        end
        ccb_pkg::CCB_ADDR_STATUS: begin
          o_rdata <= {11'h000, status};
        end
        ccb_pkg::CCB_ADDR_IO_AB: begin
          o_rdata <= {8'h00, io_ab_reg};
        end
        ccb_pkg::CCB_ADDR_IO_CD: begin
          o_rdata <= {8'h00, io_cd_reg};
        end
        ccb_pkg::CCB_ADDR_COUNT: begin
          o_rdata <= counter;
        end
        ccb_pkg::CCB_ADDR_GRA: begin
          o_rdata <= gra;
        end
        ccb_pkg::CCB_ADDR_GRB: begin
          o_rdata <= grb;
        end
        ccb_pkg::CCB_ADDR_GRC: begin
          o_rdata <= grc;
        end
        ccb_pkg::CCB_ADDR_GRD: begin
          o_rdata <= grd;
        end
        ccb_pkg::CCB_ADDR_MASK: begin
          o_rdata <= {11'h000, irq_mask};
        end
        default: begin
          // Unmapped words read as zero.
          o_rdata <= '0;
        end
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // Outputs toward the rest of the timer, all registered.
  // The interrupt follows the flags one cycle late, trading latency for a clean flop output.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_count_value <= ccb_pkg::CCB_WORD_RESET;
      o_match <= 4'h0;
    end else begin
      o_irq <= |(status & irq_mask);
      o_count_value <= counter;
      o_match <= {match_d, match_c, match_b, match_a};
    end
  end

endmodule : ccb_timer

// [sim/ccb_timer_monitor.sv]
// Checker of the port relations of the capture/compare timer.
`timescale 1ns/1ps
module ccb_timer_monitor (
  input wire logic [3:0] i_addr,
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic [15:0] o_count_value,
  input wire logic [3:0] o_match
);
  // Everything runs on the one timer clock and its reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A read strobe on one word, ending in the cycle that carries its data.
  sequence s_rd(logic [3:0] a);
    i_rd && i_addr == a ##1 1'b1;
  endsequence
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
  unmapped_zero_a: assert property (i_rd && i_addr > 4'ha |=> o_rdata == 16'h0000) else $error("unmapped read");
  mode_rsvd_a: assert property (s_rd(ccb_pkg::CCB_ADDR_MODE) |-> (o_rdata & 16'hff70) == 16'h0000)
    else $error("mode reserved bits");
  ctrl_rsvd_a: assert property (s_rd(ccb_pkg::CCB_ADDR_CTRL1) |-> o_rdata[15:4] == 12'h000)
    else $error("control reserved bits");
  status_rsvd_a: assert property (s_rd(ccb_pkg::CCB_ADDR_STATUS) |-> o_rdata[15:5] == 11'h000)
    else $error("status reserved bits");
  // The count moves by one tick, a clear, or a software write two cycles back.
  count_step_a: assert property (o_count_value != $past(o_count_value) |->
    o_count_value == $past(o_count_value) + 16'h0001 || o_count_value == 16'h0000 || $past(i_wr, 2))
    else $error("count jumped");
  match_next_a: assert property (|o_match |=>
    o_count_value == $past(o_count_value) + 16'h0001 || o_count_value == 16'h0000) else $error("match off tick");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_wr, 2)) else $error("irq dropped alone");
endmodule : ccb_timer_monitor
bind ccb_timer ccb_timer_monitor i_mon (.i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .o_rdata, .o_irq, .o_count_value,
  .o_match);

// [sim/ccb_pin_model.sv]
// Model of the outside pins: channel A, channel C, trigger and external clock.
`timescale 1ns/1ps
module ccb_pin_model (
  input wire logic i_clk,
  output logic [3:0] o_pins
);
  // Bits are {external clock, trigger, channel C, channel A}; all idle low.
  initial o_pins = 4'h0;
  // Moves one pin after an edge and holds it three clocks, so no edge is missed.
  task automatic level(input int idx, input logic val);
    @(posedge i_clk);
    o_pins[idx] <= val;
    repeat (3) @(posedge i_clk);
  endtask : level
endmodule : ccb_pin_model

// [sim/ccb_timer_tb.sv]
// Self-checking bench of the capture/compare timer.
`timescale 1ns/1ps
module ccb_timer_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [15:0] r;
  logic o_irq;
  logic [3:0] pins;
  logic osc = 1'b0;
  logic osc_on = 1'b0;
  int errors = 0;
  int num_checks = 0;
  // Writable bits of words 0 to 4; status takes none from a plain write.
  logic [7:0] wm [5] = '{8'h8f, 8'h0f, 8'h00, 8'h7f, 8'h77};
  int dv [5] = '{1, 2, 4, 8, 32};
  always #5 i_clk = ~i_clk;
  // Channel B and D pins are held quiet; the oscillator clock also feeds the alternate A capture source.
  ccb_timer i_ccb_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_a_pin(pins[0]), .i_chan_b_pin(1'b0), .i_chan_c_pin(pins[1]),
    .i_chan_d_pin(1'b0), .i_trigger_pin(pins[2]), .i_external_clock_pin(pins[3]), .i_fast_onchip_osc_clock(osc),
    .i_fast_osc_on(osc_on), .i_capture_alt_source(osc), .o_irq(o_irq), .o_count_value(), .o_match());
  ccb_pin_model i_pm (.i_clk(i_clk), .o_pins(pins));
  // Word map: 0 mode, 1 control, 2 status, 3..4 I/O select, 5 count, 6..9 A..D, a mask.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read data is looked at mid-cycle, the only cycle it stands.
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
    @(posedge i_clk);
  endtask : rd
  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // The full sequence needs under six hundred cycles, so this leaves a wide margin.
  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(22866));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
    // Bit 7 stays clear so that the counter never starts here and raises no flag.
    for (int a = 4; a >= 0; a--) begin
      r = 16'($urandom) & 16'hff7f;
      wr(4'(a), r);
      rd(4'(a), r & {8'h00, wm[a]});
      wr(4'(a), 16'h0000);
    end
    // Buffered compare: A reloads from C on its match, and C still flags.
    wr(4'h7, 16'h1000); wr(4'h9, 16'h1000); wr(4'h6, 16'h0005); wr(4'h8, 16'h0009); wr(4'ha, 16'h0005);
    wr(4'h0, 16'h0084);
    repeat (12) @(posedge i_clk);
    wr(4'h0, 16'h0004);
    rd(4'h6, 16'h0009);
    chk({15'h0000, o_irq}, 16'h0001);
    wr(4'h2, 16'h0000); rd(4'h2, 16'h0005);
    wr(4'h2, 16'h0000); rd(4'h2, 16'h0000);
    chk({15'h0000, o_irq}, 16'h0000);
    // Buffered capture on the falling edge of A; C only flags on its own edge.
    wr(4'h5, 16'h1234); wr(4'h6, 16'h0042); wr(4'h3, 16'h0005); wr(4'h4, 16'h0004);
    i_pm.level(0, 1'b1);
    rd(4'h2, 16'h0000);
    i_pm.level(0, 1'b0);
    i_pm.level(1, 1'b1);
    rd(4'h6, 16'h1234);
    rd(4'h8, 16'h0042);
    rd(4'h2, 16'h0005);
    i_pm.level(0, 1'b1);
    // PWM2: a trigger reloads B from D, and the falling A edge captures nothing.
    wr(4'h0, 16'h000a); wr(4'h9, 16'h0077); wr(4'h5, 16'h0321);
    i_pm.level(2, 1'b1);
    i_pm.level(0, 1'b0);
    rd(4'h7, 16'h0077);
    rd(4'h6, 16'h1234);
    // Each divided clock gets its share of 64 counting cycles.
    for (int k = 0; k < 5; k++) begin
      wr(4'h5, 16'h0000); wr(4'h1, 16'(k)); wr(4'h0, 16'h0080);
      repeat (62) @(posedge i_clk);
      wr(4'h0, 16'h0000);
      rd(4'h5, 16'(64 / dv[k]));
    end
    wr(4'h5, 16'h0000); wr(4'h1, 16'h0005); wr(4'h0, 16'h0080);
    repeat (4) begin
      i_pm.level(3, 1'b1);
      i_pm.level(3, 1'b0);
    end
    wr(4'h0, 16'h0000);
    rd(4'h5, 16'h0004);
    // Oscillator count, switched on before its code; each fall captures A through the alternate source.
    osc_on <= 1'b1;
    wr(4'h5, 16'h0000); wr(4'h3, 16'h000d); wr(4'h1, 16'h0006); wr(4'h0, 16'h0080);
    repeat (3) begin
      osc <= 1'b1;
      @(posedge i_clk);
      osc <= 1'b0;
      @(posedge i_clk);
    end
    wr(4'h0, 16'h0000);
    rd(4'h5, 16'h0003);
    rd(4'h6, 16'h0003);
    tally_and_finish;
  end
endmodule : ccb_timer_tb
